// [core/spr_regulator.sv]
// Purpose: PID speed regulator of a DC drive with APB register access
// Assumes: ctrl_tick_i pulses once per control period, six per supply cycle
// Notes:   all loop signals are signed counts, saturated to +/-1000 except the tacho feedback
//
// Overview of operation
// - proportional term is error times gain over eight
// - integral gain scaled 6f times setting over 256
// - derivative source: error, demand or feedback
// - integrator held in torque mode or current limit
// - feedback select bit: 1 encoder, 0 analogue
// - analogue type bit: 1 armature volts, 0 tacho
// - encoder pulses counted up to maximum rate
// - armature volts scaled full at maximum setting
// - armature voltage monitored and clamped with tacho or encoder feedback only
// - clamp level is 1.2 times maximum
// - maximum speed setting only scales displayed speed
// - IR compensation is integral times setting over 2048
// - hard reference summed when selected and reference on
// - IR droop lets speed fall with load
// - ramp output summed when selected, default on
// - fine trim maps 0..255 onto -8..+8
// - standstill threshold in 0.1 percent steps
// - error filter time constant 256 over 6f times setting
// - tacho monitor reads 1000 at full speed
// - proportional multiplier bit multiplies gain by four
// - gain reduction bit divides both gains by eight
// - loop output drives current demand downstream
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module spr_regulator
    import spr_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          en_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic          ctrl_tick_i,
    input  wire logic          enc_pulse_i,
    input  wire logic          enc_dir_i,
    input  wire spr_drive_in_t drive_i,
    output logic signed [11:0] current_demand_o,
    output logic               volt_clamp_o,
    output logic               standstill_o
);

    typedef struct packed {
        logic [7:0]         prop_gain;
        logic [7:0]         integ_gain;
        logic [7:0]         deriv_gain;
        spr_ctrl_t          ctrl;
        logic [10:0]        pulse_scale;
        logic [9:0]         max_arm_v;
        logic signed [11:0] direct_ref;
        logic [7:0]         fine_trim;
        logic [7:0]         standstill_thr;
        logic [7:0]         filter_k;
        logic [7:0]         ir_k;
        logic [10:0]        max_speed;
        logic [31:0]        rdata;
        spr_phase_t         phase;
        logic signed [15:0] enc_cnt;
        logic signed [15:0] enc_snap;
        logic signed [11:0] tacho_mon;
        logic signed [11:0] demand;
        logic signed [11:0] fb;
        logic signed [11:0] err_raw;
        logic signed [31:0] errf_acc;
        logic signed [31:0] integ_acc;
        logic signed [11:0] prev_src;
        logic signed [11:0] ir_out;
        logic signed [11:0] loop_out;
        logic               clamp;
        logic               stand;
        logic signed [11:0] spd_disp;
    } spr_state_t;

    spr_state_t s_q;
    spr_state_t s_d;

    function automatic logic signed [11:0] sat(input logic signed [31:0] v);
        if (v > SIG_MAX) begin
            return 12'(SIG_MAX);
        end else if (v < -SIG_MAX) begin
            return 12'(-SIG_MAX);
        end
        return v[11:0];
    endfunction

    logic               wr_acc;
    logic               rd_setup;
    logic               addr_ok;
    logic signed [31:0] errf;
    logic signed [31:0] integ;
    logic signed [31:0] sum;
    logic signed [31:0] pterm;
    logic signed [31:0] dterm;
    logic signed [31:0] src;
    logic signed [31:0] arm_lim;
    logic signed [31:0] clamp_out;

    always_comb begin
        case (paddr_i)
            A_PROP_GAIN, A_INTEG_GAIN, A_DERIV_GAIN, A_CONTROL, A_PULSE_SCALE, A_MAX_ARM_V,
            A_DIRECT_REF, A_FINE_TRIM, A_STANDSTILL, A_FILTER, A_IR_COMP, A_MAX_SPEED,
            A_TACHO_MON, A_LOOP_OUT, A_SPEED_ERR, A_INTEGRAL, A_SPEED_DISP, A_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_acc    = psel_i && penable_i && pwrite_i && addr_ok && en_i;
    assign rd_setup  = psel_i && !penable_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign prdata_o  = s_q.rdata;

    assign errf      = s_q.errf_acc >>> FRAC_SHIFT;
    assign integ     = s_q.integ_acc >>> FRAC_SHIFT;
    assign arm_lim   = (32'(s_q.max_arm_v) * CLAMP_NUM) / CLAMP_DEN;

    always_comb begin
        s_d = s_q;
        sum = '0;
        pterm = '0;
        dterm = '0;
        src = '0;
        clamp_out = '0;

        // read data sampled in setup so it stands from a flop in the access phase
        if (rd_setup) begin
            case (paddr_i)
                A_PROP_GAIN:   s_d.rdata = 32'(s_q.prop_gain);
                A_INTEG_GAIN:  s_d.rdata = 32'(s_q.integ_gain);
                A_DERIV_GAIN:  s_d.rdata = 32'(s_q.deriv_gain);
                A_CONTROL:     s_d.rdata = {22'h0, s_q.ctrl.dsrc, 1'b0, s_q.ctrl.gain_red, s_q.ctrl.prop_x4,
                                            s_q.ctrl.ramp_sum, s_q.ctrl.droop, s_q.ctrl.direct_sel,
                                            s_q.ctrl.arm_fb, s_q.ctrl.pulse_fb};
                A_PULSE_SCALE: s_d.rdata = 32'(s_q.pulse_scale);
                A_MAX_ARM_V:   s_d.rdata = 32'(s_q.max_arm_v);
                A_DIRECT_REF:  s_d.rdata = 32'(s_q.direct_ref);
                A_FINE_TRIM:   s_d.rdata = 32'(s_q.fine_trim);
                A_STANDSTILL:  s_d.rdata = 32'(s_q.standstill_thr);
                A_FILTER:      s_d.rdata = 32'(s_q.filter_k);
                A_IR_COMP:     s_d.rdata = 32'(s_q.ir_k);
                A_MAX_SPEED:   s_d.rdata = 32'(s_q.max_speed);
                A_TACHO_MON:   s_d.rdata = 32'(s_q.tacho_mon);
                A_LOOP_OUT:    s_d.rdata = 32'(s_q.loop_out);
                A_SPEED_ERR:   s_d.rdata = 32'(sat(errf));
                A_INTEGRAL:    s_d.rdata = 32'(sat(integ));
                A_SPEED_DISP:  s_d.rdata = 32'(s_q.spd_disp);
                A_STATUS:      s_d.rdata = {30'h0, s_q.stand, s_q.clamp};
                default:       s_d.rdata = '0;
            endcase
        end

        if (wr_acc) begin
            case (paddr_i)
                A_PROP_GAIN:   s_d.prop_gain = pwdata_i[7:0];
                A_INTEG_GAIN:  s_d.integ_gain = pwdata_i[7:0];
                A_DERIV_GAIN:  s_d.deriv_gain = pwdata_i[7:0];
                A_CONTROL: begin
                    s_d.ctrl.pulse_fb   = pwdata_i[B_PULSE_FB];
                    s_d.ctrl.arm_fb     = pwdata_i[B_ARM_FB];
                    s_d.ctrl.direct_sel = pwdata_i[B_DIRECT_SEL];
                    s_d.ctrl.droop      = pwdata_i[B_DROOP];
                    s_d.ctrl.ramp_sum   = pwdata_i[B_RAMP_SUM];
                    s_d.ctrl.prop_x4    = pwdata_i[B_PROP_X4];
                    s_d.ctrl.gain_red   = pwdata_i[B_GAIN_RED];
                    s_d.ctrl.dsrc       = pwdata_i[B_DSRC_LO +: 2];
                end
                A_PULSE_SCALE: s_d.pulse_scale = pwdata_i[10:0];
                A_MAX_ARM_V:   s_d.max_arm_v = pwdata_i[9:0];
                A_DIRECT_REF:  s_d.direct_ref = pwdata_i[11:0];
                A_FINE_TRIM:   s_d.fine_trim = pwdata_i[7:0];
                A_STANDSTILL:  s_d.standstill_thr = pwdata_i[7:0];
                A_FILTER:      s_d.filter_k = pwdata_i[7:0];
                A_IR_COMP:     s_d.ir_k = pwdata_i[7:0];
                A_MAX_SPEED:   s_d.max_speed = pwdata_i[10:0];
                default: ;
            endcase
        end

        // one count per synchronous pulse cycle, no prescale
        if (enc_pulse_i) begin
            s_d.enc_cnt = enc_dir_i ? s_q.enc_cnt - 16'sd1 : s_q.enc_cnt + 16'sd1;
        end

        case (s_q.phase)
            ST_IDLE: begin
                // one loop update per supply-locked period
                if (ctrl_tick_i) begin
                    s_d.enc_snap = s_d.enc_cnt;
                    s_d.enc_cnt  = '0;
                    // tacho already 1000 at full speed
                    s_d.tacho_mon = drive_i.tacho;
                    if (s_q.ctrl.ramp_sum) begin
                        sum = sum + 32'(drive_i.ramp_out);
                    end
                    if (s_q.ctrl.direct_sel && drive_i.ref_on) begin
                        sum = sum + 32'(s_q.direct_ref);
                    end
                    // trim of -8..+8 from 0..255
                    // upper half spans one code less, so the top code reaches the full +8
                    sum = sum + (($signed(32'(s_q.fine_trim)) - TRIM_MID) * TRIM_SPAN)
                              / ((s_q.fine_trim >= 8'(TRIM_MID)) ? TRIM_MID - 1 : TRIM_MID);
                    s_d.demand = sat(sum);
                    if (s_q.ctrl.pulse_fb) begin
                        s_d.fb = sat((32'(s_d.enc_snap) * $signed(32'(s_q.pulse_scale))) / ENC_DIV);
                    end else if (s_q.ctrl.arm_fb) begin
                        if (s_q.max_arm_v == '0) begin
                            src = '0;
                        end else begin
                            src = (32'(drive_i.arm_volts) * SIG_MAX) / $signed(32'(s_q.max_arm_v));
                        end
                        if (s_q.ctrl.droop) begin
                            src = src + 32'(s_q.ir_out);
                        end else begin
                            src = src - 32'(s_q.ir_out);
                        end
                        s_d.fb = sat(src);
                    end else begin
                        s_d.fb = drive_i.tacho;
                    end
                    s_d.err_raw = sat(32'(s_d.demand) - 32'(s_d.fb));
                    // monitor volts with tacho or encoder
                    s_d.clamp = !(s_q.ctrl.arm_fb && !s_q.ctrl.pulse_fb) && (32'(drive_i.arm_volts) > arm_lim);
                    s_d.phase = ST_FILT;
                end
            end
            ST_FILT: begin
                s_d.errf_acc = s_q.errf_acc + (32'(s_q.err_raw) - errf) * 32'(s_q.filter_k);
                s_d.phase = ST_PID;
            end
            ST_PID: begin
                // integrator held in torque or current limit
                if (!(drive_i.torque_mode || drive_i.in_i_limit || s_q.clamp)) begin
                    // tick at 6f, 8 fraction bits give /256
                    src = errf * 32'(s_q.integ_gain);
                    if (s_q.ctrl.gain_red) begin
                        src = src / GAIN_RED_DIV;
                    end
                    src = s_q.integ_acc + src;
                    if (src > (SIG_MAX <<< FRAC_SHIFT)) begin
                        src = SIG_MAX <<< FRAC_SHIFT;
                    end else if (src < -(SIG_MAX <<< FRAC_SHIFT)) begin
                        src = -(SIG_MAX <<< FRAC_SHIFT);
                    end
                    s_d.integ_acc = src;
                end
                s_d.phase = ST_OUT;
            end
            ST_OUT: begin
                pterm = (errf * $signed(32'(s_q.prop_gain))) / PROP_DIV;
                if (s_q.ctrl.prop_x4) begin
                    pterm = pterm * PROP_MUL_X4;
                end
                if (s_q.ctrl.gain_red) begin
                    pterm = pterm / GAIN_RED_DIV;
                end
                case (s_q.ctrl.dsrc)
                    DSRC_DEMAND:   src = 32'(s_q.demand);
                    DSRC_FEEDBACK: src = 32'(s_q.fb);
                    default:       src = 32'(sat(errf));
                endcase
                dterm = ((src - 32'(s_q.prev_src)) * $signed(32'(s_q.deriv_gain))) / DERIV_DIV;
                if (s_q.ctrl.dsrc != DSRC_DEMAND) begin
                    dterm = -dterm;
                end
                s_d.prev_src = src[11:0];
                clamp_out = 32'(sat(pterm + integ + dterm));
                // no positive demand while over the clamp level
                if (s_q.clamp && clamp_out > 0) begin
                    clamp_out = '0;
                end
                s_d.loop_out = sat(clamp_out);
                s_d.ir_out = sat((integ * $signed(32'(s_q.ir_k))) / IR_DIV);
                // one threshold count is 0.1 % of max
                s_d.stand = (s_q.fb >= -$signed(12'(s_q.standstill_thr))) && (s_q.fb <= $signed(12'(s_q.standstill_thr)));
                // display only, never used by the loop
                s_d.spd_disp = sat((32'(s_q.fb) * $signed(32'(s_q.max_speed))) / SPD_DISP_DIV);
                s_d.phase = ST_IDLE;
            end
            default: s_d.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q                <= '0;
            s_q.prop_gain      <= R_PROP_GAIN;
            s_q.integ_gain     <= R_INTEG_GAIN;
            s_q.deriv_gain     <= R_DERIV_GAIN;
            s_q.ctrl.ramp_sum  <= 1'b1;
            s_q.ctrl.dsrc      <= R_DSRC;
            s_q.pulse_scale    <= R_PULSE_SCALE;
            s_q.max_arm_v      <= R_MAX_ARM_V;
            s_q.fine_trim      <= R_FINE_TRIM;
            s_q.standstill_thr <= R_STANDSTILL;
            s_q.filter_k       <= R_FILTER;
            s_q.ir_k           <= R_IR_COMP;
            s_q.max_speed      <= R_MAX_SPEED;
            s_q.phase          <= ST_IDLE;
        end else if (en_i) begin
            s_q <= s_d;
        end
    end

    assign current_demand_o = s_q.loop_out;
    assign volt_clamp_o     = s_q.clamp;
    assign standstill_o     = s_q.stand;

    // checks
    loop_sequence_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_IDLE && ctrl_tick_i |=> s_q.phase == ST_FILT)
        else $error("tick did not start the loop update");
    out_range_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        current_demand_o <= 12'sd1000 && current_demand_o >= -12'sd1000)
        else $error("current demand out of range");
    integ_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_q.phase == ST_PID && (drive_i.torque_mode || drive_i.in_i_limit) |=> $stable(s_q.integ_acc))
        else $error("integrator moved while held");
    clamp_output_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_OUT && s_q.clamp |=> current_demand_o <= 12'sd0)
        else $error("positive demand during voltage clamp");
    tacho_select_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_IDLE && ctrl_tick_i && !s_q.ctrl.pulse_fb && !s_q.ctrl.arm_fb
        |=> s_q.fb == $past(drive_i.tacho))
        else $error("tacho feedback not selected");
    ramp_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_IDLE && ctrl_tick_i && !s_q.ctrl.ramp_sum && !s_q.ctrl.direct_sel
        && s_q.fine_trim == R_FINE_TRIM |=> s_q.demand == 12'sd0)
        else $error("ramp summed while deselected");
    pulse_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && enc_pulse_i && !enc_dir_i && !(s_q.phase == ST_IDLE && ctrl_tick_i)
        |=> s_q.enc_cnt == $past(s_q.enc_cnt) + 16'sd1)
        else $error("encoder pulse lost");
    stand_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_OUT && s_q.fb == 12'sd0 |=> standstill_o)
        else $error("standstill not flagged at zero speed");
    stand_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_OUT && s_q.fb > $signed(12'(s_q.standstill_thr)) |=> !standstill_o)
        else $error("standstill flagged above threshold");
    clamp_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_IDLE && ctrl_tick_i && 32'(drive_i.arm_volts) <= arm_lim |=> !volt_clamp_o)
        else $error("clamp set below the clamp level");
    enc_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i && s_q.phase == ST_IDLE && ctrl_tick_i |=> s_q.enc_cnt == 16'sd0)
        else $error("encoder count not restarted at tick");
    apb_error_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        psel_i && penable_i |-> pready_o && (pslverr_o == !addr_ok))
        else $error("bad apb answer");

endmodule

// [core/spr_pkg.sv]
// Purpose: constants, register map and types of the speed loop regulator
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   signal range of the loop is +/-1000 counts
package spr_pkg;

    localparam int          SIG_MAX        = 1000;
    localparam int          FRAC_SHIFT     = 8;     // accumulators carry 8 fraction bits
    localparam int          PROP_DIV       = 8;
    localparam int          PROP_MUL_X4    = 4;
    localparam int          GAIN_RED_DIV   = 8;
    localparam int          IR_DIV         = 2048;
    localparam int          DERIV_DIV      = 8;
    localparam int          CLAMP_NUM      = 12;    // clamp level = max * 12 / 10
    localparam int          CLAMP_DEN      = 10;
    localparam int          TRIM_MID       = 128;
    localparam int          TRIM_SPAN      = 8;
    localparam int          ENC_DIV        = 42;    // pulses*scale per control period to 0.1 % units
    localparam int          ENC_MAX_HZ     = 105000;
    localparam int          CLK_HZ         = 250000000;
    localparam int          ENC_MIN_CYC    = CLK_HZ / ENC_MAX_HZ;
    localparam int          SPD_DISP_DIV   = 1000;

    // register byte offsets
    localparam logic [7:0]  A_PROP_GAIN    = 8'h00;
    localparam logic [7:0]  A_INTEG_GAIN   = 8'h04;
    localparam logic [7:0]  A_DERIV_GAIN   = 8'h08;
    localparam logic [7:0]  A_CONTROL      = 8'h0C;
    localparam logic [7:0]  A_PULSE_SCALE  = 8'h10;
    localparam logic [7:0]  A_MAX_ARM_V    = 8'h14;
    localparam logic [7:0]  A_DIRECT_REF   = 8'h18;
    localparam logic [7:0]  A_FINE_TRIM    = 8'h1C;
    localparam logic [7:0]  A_STANDSTILL   = 8'h20;
    localparam logic [7:0]  A_FILTER       = 8'h24;
    localparam logic [7:0]  A_IR_COMP      = 8'h28;
    localparam logic [7:0]  A_MAX_SPEED    = 8'h2C;
    localparam logic [7:0]  A_TACHO_MON    = 8'h30;
    localparam logic [7:0]  A_LOOP_OUT     = 8'h34;
    localparam logic [7:0]  A_SPEED_ERR    = 8'h38;
    localparam logic [7:0]  A_INTEGRAL     = 8'h3C;
    localparam logic [7:0]  A_SPEED_DISP   = 8'h40;
    localparam logic [7:0]  A_STATUS       = 8'h44;

    // control register bit positions
    localparam int          B_PULSE_FB     = 0;
    localparam int          B_ARM_FB       = 1;
    localparam int          B_DIRECT_SEL   = 2;
    localparam int          B_DROOP        = 3;
    localparam int          B_RAMP_SUM     = 4;
    localparam int          B_PROP_X4      = 5;
    localparam int          B_GAIN_RED     = 6;
    localparam int          B_DSRC_LO      = 8;

    // reset values
    localparam logic [7:0]  R_PROP_GAIN    = 8'h50;
    localparam logic [7:0]  R_INTEG_GAIN   = 8'h10;
    localparam logic [7:0]  R_DERIV_GAIN   = 8'h00;
    localparam logic [10:0] R_PULSE_SCALE  = 11'h1A3;
    localparam logic [9:0]  R_MAX_ARM_V    = 10'h1E5;
    localparam logic [7:0]  R_FINE_TRIM    = 8'h80;
    localparam logic [7:0]  R_STANDSTILL   = 8'h10;
    localparam logic [7:0]  R_FILTER       = 8'hFF;
    localparam logic [7:0]  R_IR_COMP      = 8'h00;
    localparam logic [10:0] R_MAX_SPEED    = 11'h6D6;
    localparam logic [1:0]  R_DSRC         = 2'h1;

    localparam logic [1:0]  DSRC_ERROR     = 2'h1;
    localparam logic [1:0]  DSRC_DEMAND    = 2'h2;
    localparam logic [1:0]  DSRC_FEEDBACK  = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILT = 2'b01,
        ST_PID  = 2'b11,
        ST_OUT  = 2'b10
    } spr_phase_t;

    typedef struct packed {
        logic        pulse_fb;
        logic        arm_fb;
        logic        direct_sel;
        logic        droop;
        logic        ramp_sum;
        logic        prop_x4;
        logic        gain_red;
        logic [1:0]  dsrc;
    } spr_ctrl_t;

    // loop inputs sampled from the drive
    typedef struct packed {
        logic signed [11:0] ramp_out;
        logic               ref_on;
        logic signed [11:0] tacho;
        logic signed [11:0] arm_volts;
        logic               torque_mode;
        logic               in_i_limit;
    } spr_drive_in_t;

endpackage

// [dv/spr_motor_model.sv]
// Purpose: far-side model of the motor: feedback levels, ticks, encoder
// Assumes: bench commands speed and armature volts as levels
// Notes:   speed loop only, torque mode driven from hold_i, no current limit
`timescale 1ns/1ps
module spr_motor_model
    import spr_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic [11:0]   speed_i,
    input  wire logic [11:0]   volts_i,
    input  wire logic          hold_i,
    output logic               tick_o,
    output logic               pulse_o,
    output spr_drive_in_t      drive_o
);
    logic [11:0] cnt_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) cnt_q <= 12'h000;
        else cnt_q <= cnt_q + 12'h001;
    end
    assign tick_o  = (cnt_q[2:0] == 3'h7);
    assign pulse_o = (cnt_q == 12'hFFF);
    assign drive_o = '{ramp_out: 12'sh000, ref_on: 1'b0, tacho: speed_i, arm_volts: volts_i,
                       torque_mode: hold_i, in_i_limit: 1'b0};
endmodule

// [dv/test_spr_regulator.sv]
// Purpose: self-checking bench of the speed regulator
// Assumes: zero-wait APB slave, status settles within two ticks
// Notes:   expected reads are queued by the driver, checked by a monitor
`timescale 1ns/1ps
module test_spr_regulator
    import spr_pkg::*;
;
    logic          clk_i = 1'b0, reset_n_i = 1'b0, en_i = 1'b1;
    logic          psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]    paddr_i = 8'h00;
    logic [31:0]   pwdata_i = 32'h0, prdata_o, v;
    logic          pready_o, pslverr_o, tick, pulse;
    logic [11:0]   speed = 12'h000, volts = 12'h000;
    logic signed [11:0] demand;
    logic          clamp, stand, hold = 1'b0;
    logic [32:0]   exp_v, q[$];
    spr_drive_in_t drive;
    int            n_mismatch = 0, comparisons = 0;
    localparam logic [7:0]  RA[11] = '{A_PROP_GAIN, A_INTEG_GAIN, A_DERIV_GAIN, A_CONTROL, A_PULSE_SCALE,
        A_MAX_ARM_V, A_FINE_TRIM, A_STANDSTILL, A_FILTER, A_IR_COMP, A_MAX_SPEED};
    localparam logic [31:0] RV[11] = '{32'(R_PROP_GAIN), 32'(R_INTEG_GAIN), 32'(R_DERIV_GAIN), 32'h110,
        32'(R_PULSE_SCALE), 32'(R_MAX_ARM_V), 32'(R_FINE_TRIM), 32'(R_STANDSTILL), 32'(R_FILTER),
        32'(R_IR_COMP), 32'(R_MAX_SPEED)};
    localparam logic [31:0] RM[11] = '{32'hFF, 32'hFF, 32'hFF, 32'h37F, 32'h7FF, 32'h3FF,
        32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h7FF};
    always #2 clk_i = ~clk_i;
    spr_motor_model MOTOR (.clk_i(clk_i), .reset_n_i(reset_n_i), .speed_i(speed), .volts_i(volts), .hold_i(hold),
        .tick_o(tick), .pulse_o(pulse), .drive_o(drive));
    spr_regulator DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(en_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ctrl_tick_i(tick),
        .enc_pulse_i(pulse), .enc_dir_i(1'b0), .drive_i(drive), .current_demand_o(demand),
        .volt_clamp_o(clamp), .standstill_o(stand));
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        // only the watchdog ends a wait for the answer
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic settle();
        repeat (16) @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i) begin
            exp_v = q.pop_front();
            comparisons++;
            if ({pslverr_o, prdata_o} !== exp_v) begin
                n_mismatch++;
                $display("mismatch read %h expected %h seen %h", paddr_i, exp_v, {pslverr_o, prdata_o});
            end
            if (paddr_i == A_STATUS && {stand, clamp} !== exp_v[1:0]) begin
                n_mismatch++;
                $display("mismatch status pins expected %h seen %h", exp_v[1:0], {stand, clamp});
            end
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        void'($urandom(32'h4118));
        for (int i = 0; i < 11; i++) rd(RA[i], {1'b0, RV[i]});
        $display("test reset values done");
        speed <= 12'd16;
        volts <= 12'd582;
        settle();
        rd(A_STATUS, 33'h2);
        speed <= 12'd17;
        volts <= 12'd583;
        settle();
        rd(A_STATUS, 33'h1);
        comparisons++;
        if ((demand <= 12'sd0) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch current demand expected <= 0 seen %0d", demand);
        end
        hold <= 1'b1;
        settle();
        hold <= 1'b0;
        apb(1'b1, A_CONTROL, 32'h112);
        settle();
        rd(A_STATUS, 33'h0);
        apb(1'b1, A_CONTROL, 32'h110);
        $display("test clamp and standstill done");
        apb(1'b1, A_TACHO_MON, 32'hABC);
        rd(A_TACHO_MON, 33'd17);
        rd(8'h48, {1'b1, 32'h0});
        @(posedge clk_i);
        en_i <= 1'b0;
        apb(1'b1, A_PROP_GAIN, 32'h33);
        en_i <= 1'b1;
        rd(A_PROP_GAIN, {1'b0, RV[0]});
        $display("test refusals done");
        for (int i = 0; i < 11; i++) begin
            v = $urandom;
            apb(1'b1, RA[i], v);
            rd(RA[i], {1'b0, v & RM[i]});
        end
        $display("test random readback done");
        @(posedge clk_i);
        complete_run();
    end
endmodule
